// *** design/pulse_counter_pkg.sv ***
// Purpose: constants and types for the pulse counter holding register bank
// Assumes: 16-bit holding registers addressed by an 8-bit register number
// Notes:   all offsets are register numbers as seen by the serial master
// Notes on behaviour
// - display result read-only, high 0x01, low 0x02
// - status 0x03: valid 0, overflow 0x80, underflow 0x40
// - precounter wraps at ratio, steps main counter
// - main counter words at 0x05 and 0x06
// - threshold one at 0x07/0x08, limited 0..999
// - threshold two at 0x0b/0x0c, limited 0..999
// - 0x09 high byte picks relay one function
// - bus-driven relay one: 0x00 off, 0xff on
// - 0x0d high byte picks relay two function
// - bus-driven relay two: 0x00 off, 0xff on
// - active times at 0x0a and 0x0e, 0..999
// - 0x17 high byte: 0 self-zeroing on, 1 off
// - 0x17 low byte picks allowed clear sources
// - 0x18 holds init holdoff, 0..999 tenths
// - 0x19 high byte: standard or batching scheme
// - 0x19 low byte: 0 up, 1 down
// - 0x1a high byte zero, low byte debounce
// - counter writes 0/1/2: restart, resume, pause
// - single read of display words errors when invalid
package pulse_counter_pkg;

  // ----------------------------------------------------------------
  // register numbers
  // ----------------------------------------------------------------
  localparam logic [7:0] REG_DISP_HI    = 8'h01;
  localparam logic [7:0] REG_DISP_LO    = 8'h02;
  localparam logic [7:0] REG_DISP_STAT  = 8'h03;
  localparam logic [7:0] REG_PRESCALE   = 8'h04;
  localparam logic [7:0] REG_MAIN_HI    = 8'h05;
  localparam logic [7:0] REG_MAIN_LO    = 8'h06;
  localparam logic [7:0] REG_THR1_HI    = 8'h07;
  localparam logic [7:0] REG_THR1_LO    = 8'h08;
  localparam logic [7:0] REG_RLY1_FUNC  = 8'h09;
  localparam logic [7:0] REG_RLY1_TIME  = 8'h0a;
  localparam logic [7:0] REG_THR2_HI    = 8'h0b;
  localparam logic [7:0] REG_THR2_LO    = 8'h0c;
  localparam logic [7:0] REG_RLY2_FUNC  = 8'h0d;
  localparam logic [7:0] REG_RLY2_TIME  = 8'h0e;
  localparam logic [7:0] REG_CLEAR_OPT  = 8'h17;
  localparam logic [7:0] REG_HOLDOFF    = 8'h18;
  localparam logic [7:0] REG_SCHEME     = 8'h19;
  localparam logic [7:0] REG_DEBOUNCE   = 8'h1a;

  // ----------------------------------------------------------------
  // values and limits
  // ----------------------------------------------------------------
  localparam logic [15:0] STAT_VALID     = 16'h0000;
  localparam logic [15:0] STAT_OVERFLOW  = 16'h0080;
  localparam logic [15:0] STAT_UNDERFLOW = 16'h0040;
  localparam logic [15:0] CMD_RESTART    = 16'h0000;
  localparam logic [15:0] CMD_RESUME     = 16'h0001;
  localparam logic [15:0] CMD_PAUSE      = 16'h0002;
  localparam logic [31:0] LIMIT_999      = 32'h0000_03e7;
  localparam logic [15:0] LIMIT_999_W    = 16'h03e7;
  localparam logic [7:0]  RLY_BUS_OFF    = 8'h00;
  localparam logic [7:0]  RLY_BUS_ON     = 8'hff;
  localparam logic [7:0]  DEB_MAX_CODE   = 8'h5a;
  localparam logic [15:0] PRESCALE_RST   = 16'h0001;
  localparam logic [7:0]  EXC_ILLEGAL_VALUE = 8'h03;
  localparam logic [7:0]  EXC_ILLEGAL_ADDR  = 8'h02;
  localparam logic [7:0]  EXC_COUNT_ERROR   = 8'h80;

  // relay function codes (high byte of relay registers)
  localparam logic [7:0] FN_THRESHOLD = 8'h00;
  localparam logic [7:0] FN_FORCE_ON  = 8'h01;
  localparam logic [7:0] FN_FORCE_OFF = 8'h02;
  localparam logic [7:0] FN_BUS       = 8'h03;

  // clear source codes (low byte of clear options)
  localparam logic [7:0] CLR_ANY   = 8'h00;
  localparam logic [7:0] CLR_EXT   = 8'h01;
  localparam logic [7:0] CLR_KEY   = 8'h02;
  localparam logic [7:0] CLR_BUS   = 8'h03;

  // ----------------------------------------------------------------
  // carriers
  // ----------------------------------------------------------------
  typedef struct packed {
    logic        rd;
    logic        wr;
    logic        single;
    logic [7:0]  addr;
    logic [15:0] wdata;
  } reg_req_t;

  typedef struct packed {
    logic        valid;
    logic        exc;
    logic [7:0]  exc_code;
    logic [15:0] rdata;
  } reg_rsp_t;

  typedef enum logic [1:0] {RUN, PAUSED} cycle_state_t;

endpackage : pulse_counter_pkg

// *** design/pulse_counter_regs.sv ***
// Purpose: holding register bank and counting core of the pulse counter
// Assumes: the serial frame engine delivers one register access per request pulse
// Notes:   relay switching algorithms and display formatting live elsewhere
`timescale 1ns/10ps
module pulse_counter_regs (
  input  wire logic                          i_mclk,
  input  wire logic                          i_rst_b,
  input  wire pulse_counter_pkg::reg_req_t   i_req,
  input  wire logic                          i_pulse,
  input  wire logic                          i_ext_clear,
  input  wire logic                          i_key_clear,
  input  wire logic                          i_auto_clear,
  input  wire logic [31:0]                   i_disp_value,
  input  wire logic                          i_disp_over,
  input  wire logic                          i_disp_under,
  output pulse_counter_pkg::reg_rsp_t        o_rsp,
  output logic [31:0]                        o_main_count,
  output logic                               o_counting,
  output logic [31:0]                        o_threshold_one,
  output logic [31:0]                        o_threshold_two,
  output logic [15:0]                        o_relay1_function,
  output logic [15:0]                        o_relay2_function,
  output logic [15:0]                        o_relay1_pulse_time,
  output logic [15:0]                        o_relay2_pulse_time,
  output logic [15:0]                        o_init_holdoff,
  output logic                               o_batching,
  output logic                               o_descending,
  output logic [7:0]                         o_input_debounce,
  output logic                               o_relay1_bus_on,
  output logic                               o_relay2_bus_on
);

  // ----------------------------------------------------------------
  // storage
  // ----------------------------------------------------------------
  logic [15:0]                      prescale_q;
  logic [15:0]                      prescale_ratio_q;
  logic [31:0]                      main_q;
  logic [31:0]                      thr1_q;
  logic [31:0]                      thr2_q;
  logic [15:0]                      rly1_q;
  logic [15:0]                      rly2_q;
  logic [15:0]                      rly1_time_q;
  logic [15:0]                      rly2_time_q;
  logic [15:0]                      clear_opt_q;
  logic [15:0]                      holdoff_q;
  logic [15:0]                      scheme_q;
  logic [7:0]                       debounce_q;
  pulse_counter_pkg::cycle_state_t  state_q;
  logic                             wr_ok;
  logic [31:0]                      thr_new;
  logic                             clear_src;
  logic                             is_cmd;

  // join two words into a 32-bit quantity
  function automatic logic [31:0] join_words(input logic [15:0] hi, input logic [15:0] lo);
    join_words = {hi, lo};
  endfunction : join_words

  // fit a new high word; lower word trimmed to stay within limit, else fail
  function automatic logic [32:0] fit_high(input logic [15:0] hi, input logic [15:0] lo);
    logic [31:0] v;
    v = join_words(hi, lo);
    if (v <= pulse_counter_pkg::LIMIT_999)
      fit_high = {1'b1, v};
    else if (hi == 16'h0000)
      fit_high = {1'b1, 16'h0000, pulse_counter_pkg::LIMIT_999_W};
    else
      fit_high = {1'b0, 32'h0000_0000};
  endfunction : fit_high

  // ----------------------------------------------------------------
  // write qualification
  // ----------------------------------------------------------------
  // legal values only; a failed write answers with an illegal-value code, or an illegal-address code at 0x03 and below
  always_comb begin
    wr_ok   = 1'b1;
    thr_new = 32'h0000_0000;
    is_cmd  = (i_req.addr == pulse_counter_pkg::REG_PRESCALE) ||
              (i_req.addr == pulse_counter_pkg::REG_MAIN_HI) ||
              (i_req.addr == pulse_counter_pkg::REG_MAIN_LO);
    unique case (i_req.addr)
      pulse_counter_pkg::REG_THR1_HI: {wr_ok, thr_new} = fit_high(i_req.wdata, thr1_q[15:0]);
      pulse_counter_pkg::REG_THR1_LO: begin
        thr_new = join_words(thr1_q[31:16], i_req.wdata);
        wr_ok   = thr_new <= pulse_counter_pkg::LIMIT_999;
      end
      pulse_counter_pkg::REG_THR2_HI: {wr_ok, thr_new} = fit_high(i_req.wdata, thr2_q[15:0]);
      pulse_counter_pkg::REG_THR2_LO: begin
        thr_new = join_words(thr2_q[31:16], i_req.wdata);
        wr_ok   = thr_new <= pulse_counter_pkg::LIMIT_999;
      end
      pulse_counter_pkg::REG_RLY1_FUNC, pulse_counter_pkg::REG_RLY2_FUNC:
        wr_ok = (i_req.wdata[15:8] <= pulse_counter_pkg::FN_BUS) &&
                ((i_req.wdata[7:0] == pulse_counter_pkg::RLY_BUS_OFF) ||
                 (i_req.wdata[7:0] == pulse_counter_pkg::RLY_BUS_ON));
      pulse_counter_pkg::REG_RLY1_TIME, pulse_counter_pkg::REG_RLY2_TIME,
      pulse_counter_pkg::REG_HOLDOFF:
        wr_ok = i_req.wdata <= pulse_counter_pkg::LIMIT_999_W;
      pulse_counter_pkg::REG_CLEAR_OPT:
        wr_ok = (i_req.wdata[15:8] <= 8'h01) && (i_req.wdata[7:0] <= pulse_counter_pkg::CLR_BUS);
      pulse_counter_pkg::REG_SCHEME:
        wr_ok = (i_req.wdata[15:8] <= 8'h01) && (i_req.wdata[7:0] <= 8'h01);
      // debounce codes 0 or 10..90 in steps of ten
      pulse_counter_pkg::REG_DEBOUNCE:
        wr_ok = (i_req.wdata[15:8] == 8'h00) &&
                (i_req.wdata[7:0] <= pulse_counter_pkg::DEB_MAX_CODE) &&
                ((i_req.wdata[7:0] % 8'h0a) == 8'h00);
      // only the three cycle commands are accepted
      pulse_counter_pkg::REG_PRESCALE, pulse_counter_pkg::REG_MAIN_HI,
      pulse_counter_pkg::REG_MAIN_LO:
        wr_ok = i_req.wdata <= pulse_counter_pkg::CMD_PAUSE;
      default: wr_ok = 1'b0;
    endcase
  end

  // ----------------------------------------------------------------
  // configuration registers
  // ----------------------------------------------------------------
  // plain storage of written settings
  always_ff @(posedge i_mclk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      thr1_q      <= 32'h0000_0000;
      thr2_q      <= 32'h0000_0000;
      rly1_q      <= 16'h0000;
      rly2_q      <= 16'h0000;
      rly1_time_q <= 16'h0000;
      rly2_time_q <= 16'h0000;
      clear_opt_q <= 16'h0000;
      holdoff_q   <= 16'h0000;
      scheme_q    <= 16'h0000;
      debounce_q  <= 8'h00;
    end else if (i_req.wr && wr_ok) begin
      unique case (i_req.addr)
        // pair stored as high over low
        pulse_counter_pkg::REG_THR1_HI,
        pulse_counter_pkg::REG_THR1_LO:   thr1_q <= thr_new;
        pulse_counter_pkg::REG_THR2_HI,
        pulse_counter_pkg::REG_THR2_LO:   thr2_q <= thr_new;
        pulse_counter_pkg::REG_RLY1_FUNC: rly1_q <= i_req.wdata;
        pulse_counter_pkg::REG_RLY2_FUNC: rly2_q <= i_req.wdata;
        pulse_counter_pkg::REG_RLY1_TIME: rly1_time_q <= i_req.wdata;
        pulse_counter_pkg::REG_RLY2_TIME: rly2_time_q <= i_req.wdata;
        pulse_counter_pkg::REG_CLEAR_OPT: clear_opt_q <= i_req.wdata;
        pulse_counter_pkg::REG_HOLDOFF:   holdoff_q <= i_req.wdata;
        pulse_counter_pkg::REG_SCHEME:    scheme_q <= i_req.wdata;
        pulse_counter_pkg::REG_DEBOUNCE:  debounce_q <= i_req.wdata[7:0];
        default: ;
      endcase
    end
  end

  // the ratio itself lives in the framing block's domain; fixed here
  always_ff @(posedge i_mclk or negedge i_rst_b) begin
    if (!i_rst_b)
      prescale_ratio_q <= pulse_counter_pkg::PRESCALE_RST;
    else
      prescale_ratio_q <= prescale_ratio_q;
  end

  // ----------------------------------------------------------------
  // cycle control
  // ----------------------------------------------------------------
  // clear sources filtered by option
  always_comb begin
    unique case (clear_opt_q[7:0])
      pulse_counter_pkg::CLR_ANY: clear_src = i_ext_clear | i_key_clear;
      pulse_counter_pkg::CLR_EXT: clear_src = i_ext_clear;
      pulse_counter_pkg::CLR_KEY: clear_src = i_key_clear;
      default:                    clear_src = 1'b0;
    endcase
    if (clear_opt_q[15:8] == 8'h00)
      clear_src = clear_src | i_auto_clear;
  end

  // pause and resume by command write
  always_ff @(posedge i_mclk or negedge i_rst_b) begin
    if (!i_rst_b)
      state_q <= pulse_counter_pkg::RUN;
    else if (i_req.wr && wr_ok && is_cmd) begin
      if (i_req.wdata == pulse_counter_pkg::CMD_PAUSE)
        state_q <= pulse_counter_pkg::PAUSED;
      else
        state_q <= pulse_counter_pkg::RUN;
    end
  end

  // precounter wraps and steps the main counter
  always_ff @(posedge i_mclk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      prescale_q <= 16'h0000;
      main_q     <= 32'h0000_0000;
    end else if ((i_req.wr && wr_ok && is_cmd &&
                  i_req.wdata == pulse_counter_pkg::CMD_RESTART) || clear_src) begin
      prescale_q <= 16'h0000;
      main_q     <= 32'h0000_0000;
    end else if (i_pulse && state_q == pulse_counter_pkg::RUN) begin
      if (prescale_q + 16'h0001 >= prescale_ratio_q) begin
        prescale_q <= 16'h0000;
        if (scheme_q[0])
          main_q <= main_q - 32'h0000_0001;
        else
          main_q <= main_q + 32'h0000_0001;
      end else begin
        prescale_q <= prescale_q + 16'h0001;
      end
    end
  end

  // ----------------------------------------------------------------
  // read answers
  // ----------------------------------------------------------------
  // one answer per request, one cycle later
  always_ff @(posedge i_mclk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      o_rsp <= '0;
    end else begin
      o_rsp.valid    <= i_req.rd | i_req.wr;
      o_rsp.exc      <= 1'b0;
      o_rsp.exc_code <= 8'h00;
      o_rsp.rdata    <= 16'h0000;
      if (i_req.wr) begin
        if (!wr_ok) begin
          o_rsp.exc      <= 1'b1;
          o_rsp.exc_code <= (i_req.addr <= pulse_counter_pkg::REG_DISP_STAT)
                            ? pulse_counter_pkg::EXC_ILLEGAL_ADDR
                            : pulse_counter_pkg::EXC_ILLEGAL_VALUE;
        end
      end else if (i_req.rd) begin
        unique case (i_req.addr)
          pulse_counter_pkg::REG_DISP_HI:   o_rsp.rdata <= i_disp_value[31:16];
          pulse_counter_pkg::REG_DISP_LO:   o_rsp.rdata <= i_disp_value[15:0];
          pulse_counter_pkg::REG_DISP_STAT:
            o_rsp.rdata <= i_disp_over  ? pulse_counter_pkg::STAT_OVERFLOW  :
                           i_disp_under ? pulse_counter_pkg::STAT_UNDERFLOW :
                           pulse_counter_pkg::STAT_VALID;
          pulse_counter_pkg::REG_PRESCALE:  o_rsp.rdata <= prescale_q;
          pulse_counter_pkg::REG_MAIN_HI:   o_rsp.rdata <= main_q[31:16];
          pulse_counter_pkg::REG_MAIN_LO:   o_rsp.rdata <= main_q[15:0];
          pulse_counter_pkg::REG_THR1_HI:   o_rsp.rdata <= thr1_q[31:16];
          pulse_counter_pkg::REG_THR1_LO:   o_rsp.rdata <= thr1_q[15:0];
          pulse_counter_pkg::REG_RLY1_FUNC: o_rsp.rdata <= rly1_q;
          pulse_counter_pkg::REG_RLY1_TIME: o_rsp.rdata <= rly1_time_q;
          pulse_counter_pkg::REG_THR2_HI:   o_rsp.rdata <= thr2_q[31:16];
          pulse_counter_pkg::REG_THR2_LO:   o_rsp.rdata <= thr2_q[15:0];
          pulse_counter_pkg::REG_RLY2_FUNC: o_rsp.rdata <= rly2_q;
          pulse_counter_pkg::REG_RLY2_TIME: o_rsp.rdata <= rly2_time_q;
          pulse_counter_pkg::REG_CLEAR_OPT: o_rsp.rdata <= clear_opt_q;
          pulse_counter_pkg::REG_HOLDOFF:   o_rsp.rdata <= holdoff_q;
          pulse_counter_pkg::REG_SCHEME:    o_rsp.rdata <= scheme_q;
          pulse_counter_pkg::REG_DEBOUNCE:  o_rsp.rdata <= {8'h00, debounce_q};
          default: begin
            o_rsp.exc      <= 1'b1;
            o_rsp.exc_code <= pulse_counter_pkg::EXC_ILLEGAL_ADDR;
          end
        endcase
        // invalid display refuses a single-word read
        if (i_req.single && (i_disp_over || i_disp_under) &&
            (i_req.addr == pulse_counter_pkg::REG_DISP_HI ||
             i_req.addr == pulse_counter_pkg::REG_DISP_LO)) begin
          o_rsp.exc      <= 1'b1;
          o_rsp.exc_code <= pulse_counter_pkg::EXC_COUNT_ERROR;
          o_rsp.rdata    <= 16'h0000;
        end
      end
    end
  end

  // ----------------------------------------------------------------
  // settings outputs, registered
  // ----------------------------------------------------------------
  // every output comes from a flop, one cycle behind the store
  always_ff @(posedge i_mclk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      o_main_count        <= 32'h0000_0000;
      o_counting          <= 1'b0;
      o_threshold_one     <= 32'h0000_0000;
      o_threshold_two     <= 32'h0000_0000;
      o_relay1_function   <= 16'h0000;
      o_relay2_function   <= 16'h0000;
      o_relay1_pulse_time <= 16'h0000;
      o_relay2_pulse_time <= 16'h0000;
      o_init_holdoff      <= 16'h0000;
      o_batching          <= 1'b0;
      o_descending        <= 1'b0;
      o_input_debounce    <= 8'h00;
      o_relay1_bus_on     <= 1'b0;
      o_relay2_bus_on     <= 1'b0;
    end else begin
      o_main_count        <= main_q;
      o_counting          <= state_q == pulse_counter_pkg::RUN;
      o_threshold_one     <= thr1_q;
      o_threshold_two     <= thr2_q;
      o_relay1_function   <= rly1_q;
      o_relay2_function   <= rly2_q;
      o_relay1_pulse_time <= rly1_time_q;
      o_relay2_pulse_time <= rly2_time_q;
      o_init_holdoff      <= holdoff_q;
      o_batching          <= scheme_q[8];
      o_descending        <= scheme_q[0];
      o_input_debounce    <= debounce_q;
      // relay one and relay two bus states, time ignored
      o_relay1_bus_on     <= rly1_q[15:8] == pulse_counter_pkg::FN_BUS &&
                             rly1_q[7:0] == pulse_counter_pkg::RLY_BUS_ON;
      o_relay2_bus_on     <= rly2_q[15:8] == pulse_counter_pkg::FN_BUS &&
                             rly2_q[7:0] == pulse_counter_pkg::RLY_BUS_ON;
    end
  end

  // ----------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------
  chk_thr_limit: assert property (@(posedge i_mclk) disable iff (!i_rst_b)
    thr1_q <= pulse_counter_pkg::LIMIT_999)
    else $error("threshold one out of range");
  chk_thr2_limit: assert property (@(posedge i_mclk) disable iff (!i_rst_b)
    thr2_q <= pulse_counter_pkg::LIMIT_999)
    else $error("threshold two out of range");
  chk_disp_exc: assert property (@(posedge i_mclk) disable iff (!i_rst_b)
    (i_req.rd && i_req.single && (i_disp_over || i_disp_under) &&
     (i_req.addr == pulse_counter_pkg::REG_DISP_HI || i_req.addr == pulse_counter_pkg::REG_DISP_LO))
    |=> (o_rsp.exc && o_rsp.exc_code == pulse_counter_pkg::EXC_COUNT_ERROR))
    else $error("invalid display read not refused");
  chk_status_over: assert property (@(posedge i_mclk) disable iff (!i_rst_b)
    (i_req.rd && i_req.addr == pulse_counter_pkg::REG_DISP_STAT && i_disp_over)
    |=> o_rsp.rdata == pulse_counter_pkg::STAT_OVERFLOW)
    else $error("status overflow wrong");
  chk_pause_hold: assert property (@(posedge i_mclk) disable iff (!i_rst_b)
    (state_q == pulse_counter_pkg::PAUSED && !clear_src && !(i_req.wr && is_cmd))
    |=> main_q == $past(main_q))
    else $error("paused counter moved");
  chk_count_dir: assert property (@(posedge i_mclk) disable iff (!i_rst_b)
    (main_q != $past(main_q) && $past(main_q) != 32'h0000_0000 && main_q != 32'h0000_0000)
    |-> main_q == ($past(scheme_q[0]) ? $past(main_q) - 32'h0000_0001
                                      : $past(main_q) + 32'h0000_0001))
    else $error("main counter stepped wrong way");
  chk_deb_high: assert property (@(posedge i_mclk) disable iff (!i_rst_b)
    (i_req.rd && i_req.addr == pulse_counter_pkg::REG_DEBOUNCE) |=> o_rsp.rdata[15:8] == 8'h00)
    else $error("debounce high byte nonzero");
  chk_bus_relay: assert property (@(posedge i_mclk) disable iff (!i_rst_b)
    ##1 (o_relay1_bus_on == ($past(rly1_q) == {pulse_counter_pkg::FN_BUS,
                                               pulse_counter_pkg::RLY_BUS_ON})))
    else $error("relay one bus state wrong");
  cov_pause: cover property (@(posedge i_mclk) state_q == pulse_counter_pkg::PAUSED);
  cov_wrap: cover property (@(posedge i_mclk) i_pulse && prescale_q == 16'h0000 && main_q != 0);
  cov_disp_err: cover property (@(posedge i_mclk) o_rsp.exc &&
    o_rsp.exc_code == pulse_counter_pkg::EXC_COUNT_ERROR);

endmodule : pulse_counter_regs

// *** tb/bus_master_model.sv ***
// Purpose: serial master stand-in, one register access at a time
// Assumes: answer shows within one cycle of the taking edge
// Notes:   released request shows cleared flags and inverted address and data, never stale ones
`timescale 1ns/10ps
module bus_master_model (
  input  wire logic                        i_mclk,
  input  wire pulse_counter_pkg::reg_rsp_t i_rsp,
  output pulse_counter_pkg::reg_req_t      o_req
);
  // ----------------
  // access task
  // ----------------
  initial o_req = '0;
  task automatic access(input logic wr, input logic [7:0] a, input logic [15:0] d,
                        output pulse_counter_pkg::reg_rsp_t r);
    @(negedge i_mclk);
    o_req = {~wr, wr, 1'b1, a, d};
    @(negedge i_mclk);
    r = i_rsp;
    o_req = {3'b000, ~a, ~d}; // idle bus must not look valid
    if (r.valid !== 1'b1) begin
      @(negedge i_mclk);
      r = i_rsp;
    end
  endtask : access
endmodule : bus_master_model

// *** tb/testbench.sv ***
// Purpose: self-checking bench of the holding register bank
// Assumes: prescale ratio of one
// Notes:   table rows first, display and counting cases by hand
`timescale 1ns/10ps
module testbench;
  logic i_mclk, i_rst_b, i_pulse, i_ov, i_un;
  logic [31:0] i_dv, o_thr;
  logic o_b1, o_b2, o_dn, o_bt, o_cnt, i_ec, i_kc, i_ac;
  logic [31:0] o_mc, o_thr2;
  logic [15:0] o_f1, o_f2, o_t1, o_t2, o_ho;
  logic [7:0] o_deb;
  pulse_counter_pkg::reg_req_t req;
  pulse_counter_pkg::reg_rsp_t rsp;
  int n_errors = 0, n_tests = 0, cyc = 0;
  // rows: wr, addr, wdata, exc, rdata or code
  logic [41:0] rows [22] = '{
    {1'b1, 8'h07, 16'h0000, 1'b0, 16'h0}, {1'b1, 8'h08, 16'h03e7, 1'b0, 16'h0},
    {1'b1, 8'h08, 16'h03e8, 1'b1, 16'h3}, {1'b0, 8'h08, 16'h0, 1'b0, 16'h03e7},
    {1'b1, 8'h0c, 16'h01f4, 1'b0, 16'h0}, {1'b0, 8'h0c, 16'h0, 1'b0, 16'h01f4},
    {1'b1, 8'h09, 16'h03ff, 1'b0, 16'h0}, {1'b1, 8'h09, 16'h0312, 1'b1, 16'h3},
    {1'b1, 8'h0d, 16'h03ff, 1'b0, 16'h0}, {1'b1, 8'h0a, 16'h03e8, 1'b1, 16'h3},
    {1'b1, 8'h17, 16'h0103, 1'b0, 16'h0}, {1'b1, 8'h18, 16'h03e7, 1'b0, 16'h0},
    {1'b1, 8'h19, 16'h0101, 1'b0, 16'h0}, {1'b0, 8'h1a, 16'h0, 1'b0, 16'h0000},
    {1'b1, 8'h01, 16'h0000, 1'b1, 16'h2}, {1'b1, 8'h17, 16'h0204, 1'b1, 16'h3},
    {1'b1, 8'h0e, 16'h0064, 1'b0, 16'h0}, {1'b0, 8'h0e, 16'h0, 1'b0, 16'h0064},
    {1'b1, 8'h1a, 16'h0014, 1'b0, 16'h0}, {1'b1, 8'h1a, 16'h0015, 1'b1, 16'h3},
    {1'b0, 8'h1a, 16'h0, 1'b0, 16'h0014}, {1'b1, 8'h0b, 16'h0001, 1'b1, 16'h3}};
  pulse_counter_regs pulse_counter_regs_inst (
    .i_mclk(i_mclk), .i_rst_b(i_rst_b), .i_req(req), .i_pulse(i_pulse),
    .i_ext_clear(i_ec), .i_key_clear(i_kc), .i_auto_clear(i_ac), .i_disp_value(i_dv),
    .i_disp_over(i_ov), .i_disp_under(i_un), .o_rsp(rsp), .o_main_count(o_mc),
    .o_counting(o_cnt), .o_threshold_one(o_thr), .o_threshold_two(o_thr2),
    .o_relay1_function(o_f1), .o_relay2_function(o_f2), .o_relay1_pulse_time(o_t1),
    .o_relay2_pulse_time(o_t2), .o_init_holdoff(o_ho), .o_batching(o_bt),
    .o_descending(o_dn), .o_input_debounce(o_deb),
    .o_relay1_bus_on(o_b1), .o_relay2_bus_on(o_b2));
  bus_master_model bus_master_model_inst (.i_mclk(i_mclk), .i_rsp(rsp), .o_req(req));
  // ----------------
  // checks and closing
  // ----------------
  task automatic chk(input logic [31:0] g, input logic [31:0] x);
    n_tests++;
    if (g !== x) begin
      n_errors++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, g, x);
    end
  endtask : chk
  task automatic op(input logic [41:0] r);
    pulse_counter_pkg::reg_rsp_t a;
    bus_master_model_inst.access(r[41], r[40:33], r[32:17], a);
    chk({a.valid, a.exc}, {1'b1, r[16]});
    if (r[16]) chk(a.exc_code, r[7:0]);
    else if (!r[41]) chk(a.rdata, r[15:0]);
  endtask : op
  task automatic stop_test();
    if (n_errors == 0 && n_tests > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask : stop_test
  // clock and hang guard, generous beside the hundred or so cycles used
  initial begin
    i_mclk = 1'b0;
    forever #10 i_mclk = ~i_mclk;
  end
  always @(posedge i_mclk) begin
    cyc++;
    if (cyc == 5000) begin
      n_errors++;
      stop_test();
    end
  end
  // main sequence
  initial begin
    {i_rst_b, i_pulse, i_ov, i_un, i_ec, i_kc, i_ac} = '0;
    i_dv = 32'h0001_0057;
    repeat (6) @(negedge i_mclk);
    i_rst_b = 1'b1;
    chk(o_thr, 32'h0);
    foreach (rows[i]) op(rows[i]);
    chk({o_thr[15:0], o_b1, o_b2, o_bt, o_dn, o_cnt}, {16'h03e7, 4'hf, 1'b1});
    chk(o_thr2, 32'h0000_01f4);
    chk({o_f1, o_f2}, {16'h03ff, 16'h03ff});
    chk({o_t1, o_t2}, {16'h0000, 16'h0064});
    chk({o_ho, 8'h00, o_deb}, {16'h03e7, 16'h0014});
    op({1'b0, 8'h01, 16'h0, 1'b0, 16'h0001});
    op({1'b0, 8'h02, 16'h0, 1'b0, 16'h0057});
    i_ov = 1'b1;
    op({1'b0, 8'h03, 16'h0, 1'b0, 16'h0080});
    op({1'b0, 8'h02, 16'h0, 1'b1, 16'h0080});
    {i_ov, i_un} = 2'b01;
    op({1'b0, 8'h03, 16'h0, 1'b0, 16'h0040});
    i_un = 1'b0;
    op({1'b1, 8'h19, 16'h0000, 1'b0, 16'h0});
    op({1'b1, 8'h04, 16'h0000, 1'b0, 16'h0});
    i_pulse = 1'b1;
    repeat (3) @(negedge i_mclk);
    i_pulse = 1'b0;
    op({1'b0, 8'h06, 16'h0, 1'b0, 16'h0003});
    op({1'b1, 8'h05, 16'h0002, 1'b0, 16'h0});
    i_pulse = 1'b1;
    repeat (2) @(negedge i_mclk);
    i_pulse = 1'b0;
    op({1'b0, 8'h06, 16'h0, 1'b0, 16'h0003});
    chk({o_mc[30:0], o_cnt}, {31'h3, 1'b0});
    // clears filtered by source option, then self-zeroing enabled
    {i_ec, i_kc, i_ac} = 3'b111;
    @(negedge i_mclk);
    {i_ec, i_kc, i_ac} = 3'b000;
    op({1'b0, 8'h06, 16'h0, 1'b0, 16'h0003});
    op({1'b1, 8'h17, 16'h0001, 1'b0, 16'h0});
    i_kc = 1'b1;
    @(negedge i_mclk);
    i_kc = 1'b0;
    op({1'b0, 8'h06, 16'h0, 1'b0, 16'h0003});
    i_ac = 1'b1;
    @(negedge i_mclk);
    i_ac = 1'b0;
    op({1'b0, 8'h06, 16'h0, 1'b0, 16'h0000});
    // resume, refused command, then up and down steps
    op({1'b1, 8'h06, 16'h0001, 1'b0, 16'h0});
    op({1'b1, 8'h06, 16'h0003, 1'b1, 16'h3});
    i_pulse = 1'b1;
    repeat (2) @(negedge i_mclk);
    i_pulse = 1'b0;
    op({1'b0, 8'h06, 16'h0, 1'b0, 16'h0002});
    op({1'b1, 8'h19, 16'h0001, 1'b0, 16'h0});
    i_pulse = 1'b1;
    @(negedge i_mclk);
    i_pulse = 1'b0;
    op({1'b0, 8'h06, 16'h0, 1'b0, 16'h0001});
    chk({o_mc[30:0], o_cnt, o_dn}, {31'h1, 2'b11});
    // second reset in mid-run
    i_rst_b = 1'b0;
    @(negedge i_mclk);
    i_rst_b = 1'b1;
    @(negedge i_mclk);
    chk({o_thr[15:0], o_mc[15:0]}, 32'h0);
    op({1'b0, 8'h19, 16'h0, 1'b0, 16'h0000});
    stop_test();
  end
endmodule : testbench
